// file: rtl/hold_timer.sv
// counts how long a level has been held and pulses on reaching a limit
`timescale 1ns/100ps
`default_nettype none
module hold_timer
  import key_switch_pkg::*;
(
  input wire logic i_sys_clk,
  input wire logic i_rst_b,
  input wire logic i_hold,
  input wire logic [31:0] i_limit,
  input wire logic i_repeat,
  output logic o_fire
);
  logic [31:0] cnt;
  logic done;
  logic [31:0] next_cnt;

  assign next_cnt = cnt + 32'h00000001;

  // one fire per hold unless repeating; a release restarts the count
  always_ff @(posedge i_sys_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      cnt <= 32'h00000000;
      done <= 1'b0;
      o_fire <= 1'b0;
    end else if (!i_hold) begin
      cnt <= 32'h00000000;
      done <= 1'b0;
      o_fire <= 1'b0;
    end else if (done) begin
      o_fire <= 1'b0;
    end else if (next_cnt >= i_limit) begin
      cnt <= 32'h00000000;
      done <= !i_repeat;
      o_fire <= 1'b1;
    end else begin
      cnt <= next_cnt;
      o_fire <= 1'b0;
    end
  end

  sequence held_to_limit_s;
    i_hold && (next_cnt >= i_limit) && !done;
  endsequence

  hold_fire_a: assert property (@(posedge i_sys_clk) disable iff (!i_rst_b)
    held_to_limit_s |=> o_fire)
    else $error("hold limit reached without fire");
  fire_cause_a: assert property (@(posedge i_sys_clk) disable iff (!i_rst_b)
    o_fire |-> $past(i_hold) && ($past(next_cnt) >= $past(i_limit)))
    else $error("fire without full hold");
endmodule : hold_timer
`default_nettype wire

// file: rtl/key_sampler.sv
// periodic sampling and three-sample debounce of the application keys
`timescale 1ns/100ps
`default_nettype none
module key_sampler
  import key_switch_pkg::*;
#(
  parameter int SAMPLE_TICKS = SAMPLE_CYCLES
) (
  input wire logic i_sys_clk,
  input wire logic i_rst_b,
  input wire logic i_enable,
  input wire logic [KEY_COUNT-1:0] i_keys,
  output logic [KEY_COUNT-1:0] o_stable,
  output logic o_on_evt,
  output logic o_off_evt
);
  logic [31:0] tick_cnt;
  logic tick;
  logic [KEY_COUNT-1:0] hist [DEBOUNCE_SAMPLES-1];
  logic agree;

  assign tick = (tick_cnt == 32'(SAMPLE_TICKS - 1));

  always_ff @(posedge i_sys_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      tick_cnt <= 32'h00000000;
    end else if (tick) begin
      tick_cnt <= 32'h00000000;
    end else begin
      tick_cnt <= tick_cnt + 32'h00000001;
    end
  end

  // older samples kept in a short shift line
  always_comb begin
    agree = 1'b1;
    for (int k = 0; k < DEBOUNCE_SAMPLES - 1; k++) begin
      agree = agree && (hist[k] == i_keys);
    end
  end

  generate
    for (genvar g = 0; g < DEBOUNCE_SAMPLES - 1; g++) begin : g_hist
      always_ff @(posedge i_sys_clk or negedge i_rst_b) begin
        if (!i_rst_b) begin
          hist[g] <= '0;
        end else if (!i_enable) begin
          hist[g] <= '0;
        end else if (tick) begin
          hist[g] <= (g == 0) ? i_keys : hist[(g == 0) ? 0 : g - 1];
        end
      end
    end
  endgenerate

  // disabling drops the pattern silently, without release events
  always_ff @(posedge i_sys_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      o_stable <= '0;
      o_on_evt <= 1'b0;
      o_off_evt <= 1'b0;
    end else if (!i_enable) begin
      o_stable <= '0;
      o_on_evt <= 1'b0;
      o_off_evt <= 1'b0;
    end else if (tick && agree && (i_keys != o_stable)) begin
      o_stable <= i_keys;
      o_on_evt <= |(i_keys & ~o_stable);
      o_off_evt <= |(o_stable & ~i_keys);
    end else begin
      o_on_evt <= 1'b0;
      o_off_evt <= 1'b0;
    end
  end

  stable_on_tick_a: assert property (@(posedge i_sys_clk) disable iff (!i_rst_b)
    (i_enable && $past(i_enable) && $changed(o_stable)) |-> $past(tick) && $past(agree))
    else $error("pattern changed without three agreeing samples");
endmodule : key_sampler
`default_nettype wire

// file: rtl/key_switch_controller.sv
// key-switch controller: power, reset and nmi buttons, debounced keys, event flags
//
// The strobed register port was left to the implementer.
`timescale 1ns/100ps
`default_nettype none
module key_switch_controller
  import key_switch_pkg::*;
#(
  parameter int SAMPLE_TICKS = SAMPLE_CYCLES,
  parameter int POWER_ON_TICKS = POWER_ON_CYCLES,
  parameter int POWER_OFF_TICKS = POWER_OFF_CYCLES,
  parameter int REPEAT_BASE_TICKS = REPEAT_BASE_CYCLES,
  parameter int REPEAT_STEP_TICKS = REPEAT_STEP_CYCLES
) (
  input wire logic i_sys_clk,
  input wire logic i_rst_b,
  input wire logic [7:0] i_addr,
  input wire logic [15:0] i_wdata,
  input wire logic i_wr,
  input wire logic i_rd,
  output logic [15:0] o_rdata,
  input wire logic i_power_btn,
  input wire logic i_reset_btn,
  input wire logic i_nmi_btn,
  input wire logic [KEY_COUNT-1:0] i_app_keys,
  output logic o_sys_power,
  output logic o_nmi_req,
  output logic o_irq
);
  logic [7:0] key_control;
  logic [7:0] repeat_interval_select;
  logic [EVENT_COUNT-1:0] flags;
  logic key_summary_flag;
  power_state_t power_state;
  logic [KEY_COUNT-1:0] stable;
  logic on_evt;
  logic off_evt;
  logic pwr_fire;
  logic rep_fire;
  logic rep_hold;
  logic [31:0] pwr_limit;
  logic [31:0] rep_limit;
  logic [EVENT_COUNT-1:0] events;
  logic [EVENT_COUNT-1:0] irq_en;
  logic [15:0] key_pattern;
  logic [15:0] next_rdata;
  logic status_wr;
  logic summary_wr;

  // lowest set bit of the one-hot select, so a mis-set register uses the shortest time
  function automatic logic [2:0] shortest_sel(input logic [7:0] sel);
    shortest_sel = 3'h0;
    for (int k = 7; k >= 0; k--) begin
      if (sel[k]) begin
        shortest_sel = 3'(k);
      end
    end
  endfunction : shortest_sel

  function automatic logic [15:0] pattern_of(input logic [KEY_COUNT-1:0] keys);
    pattern_of = 16'h0000;
    pattern_of[CURSOR_KEYS-1:0] = keys[CURSOR_KEYS-1:0];
    pattern_of[PAT_SW2_BIT] = keys[CURSOR_KEYS];
    pattern_of[PAT_SW3_BIT] = keys[CURSOR_KEYS+1];
  endfunction : pattern_of

  assign status_wr = i_wr && (i_addr == KEY_STATUS_ADDR);
  assign summary_wr = i_wr && (i_addr == SUMMARY_ADDR);
  assign irq_en = key_control[IRQ_EN_LSB +: EVENT_COUNT];
  assign key_pattern = pattern_of(stable);

  // register writes
  always_ff @(posedge i_sys_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      key_control <= KEY_CONTROL_RST;
    end else if (i_wr && (i_addr == KEY_CONTROL_ADDR)) begin
      key_control <= {2'h0, i_wdata[5:0]};
    end
  end

  always_ff @(posedge i_sys_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      repeat_interval_select <= REPEAT_SEL_RST;
    end else if (i_wr && (i_addr == REPEAT_SEL_ADDR)) begin
      repeat_interval_select <= i_wdata[7:0];
    end
  end

  key_sampler #(
    .SAMPLE_TICKS(SAMPLE_TICKS)
  ) u_sampler (
    .i_sys_clk(i_sys_clk),
    .i_rst_b(i_rst_b),
    .i_enable(key_control[KEY_IN_EN_BIT]),
    .i_keys(i_app_keys),
    .o_stable(stable),
    .o_on_evt(on_evt),
    .o_off_evt(off_evt)
  );

  // power button: the hold needed depends on whether the board is on
  assign pwr_limit = (power_state == PWR_ON) ? 32'(POWER_OFF_TICKS) : 32'(POWER_ON_TICKS);

  hold_timer u_power_timer (
    .i_sys_clk(i_sys_clk),
    .i_rst_b(i_rst_b),
    .i_hold(i_power_btn && !i_reset_btn),
    .i_limit(pwr_limit),
    .i_repeat(1'b0),
    .o_fire(pwr_fire)
  );

  always_ff @(posedge i_sys_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      power_state <= POWER_RST;
      o_sys_power <= 1'b0;
    end else if (i_reset_btn) begin
      power_state <= PWR_OFF;
      o_sys_power <= 1'b0;
    end else if (pwr_fire) begin
      unique case (power_state)
        PWR_OFF: begin
          power_state <= PWR_ON;
          o_sys_power <= 1'b1;
        end
        PWR_ON: begin
          power_state <= PWR_OFF;
          o_sys_power <= 1'b0;
        end
      endcase
    end
  end

  // repeat restarts on any pattern change; the one-cycle hold drop clears the count
  assign rep_hold = (|stable) && !on_evt && !off_evt && (|repeat_interval_select);
  assign rep_limit = 32'(REPEAT_BASE_TICKS) + 32'(shortest_sel(repeat_interval_select)) *
    32'(REPEAT_STEP_TICKS);

  hold_timer u_repeat_timer (
    .i_sys_clk(i_sys_clk),
    .i_rst_b(i_rst_b),
    .i_hold(rep_hold),
    .i_limit(rep_limit),
    .i_repeat(1'b1),
    .o_fire(rep_fire)
  );

  assign events = {pwr_fire && (power_state == PWR_ON), rep_fire, off_evt, on_evt};

  // sticky flags: a new event beats a clearing write in the same cycle
  generate
    for (genvar g = 0; g < EVENT_COUNT; g++) begin : g_flag
      always_ff @(posedge i_sys_clk or negedge i_rst_b) begin
        if (!i_rst_b) begin
          flags[g] <= FLAGS_RST[g];
        end else begin
          flags[g] <= events[g] || (flags[g] && !(status_wr && !i_wdata[FLAG_LSB+g]));
        end
      end
    end
  endgenerate

  always_ff @(posedge i_sys_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      key_summary_flag <= 1'b0;
    end else begin
      key_summary_flag <= (|events) ||
        (key_summary_flag && !(summary_wr && !i_wdata[SUMMARY_BIT]) && (|flags));
    end
  end

  always_ff @(posedge i_sys_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      o_irq <= 1'b0;
    end else begin
      o_irq <= |(flags & irq_en);
    end
  end

  always_ff @(posedge i_sys_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      o_nmi_req <= 1'b0;
    end else begin
      o_nmi_req <= i_nmi_btn && key_control[NMI_GATE_BIT];
    end
  end

  always_comb begin
    unique case (i_addr)
      KEY_CONTROL_ADDR: next_rdata = {8'h00, key_control};
      REPEAT_SEL_ADDR: next_rdata = {8'h00, repeat_interval_select};
      KEY_STATUS_ADDR: next_rdata = {11'h000, flags, 1'b0};
      KEY_PATTERN_ADDR: next_rdata = key_pattern;
      SUMMARY_ADDR: next_rdata = 16'(key_summary_flag) << SUMMARY_BIT;
      default: next_rdata = RDATA_RST;
    endcase
  end

  // read data last exactly one cycle after the strobe
  always_ff @(posedge i_sys_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      o_rdata <= RDATA_RST;
    end else if (i_rd) begin
      o_rdata <= next_rdata;
    end else begin
      o_rdata <= RDATA_RST;
    end
  end

  default clocking cb @(posedge i_sys_clk);
  endclocking
  default disable iff (!i_rst_b);

  sequence power_step_s;
    pwr_fire && !i_reset_btn;
  endsequence

  power_on_a: assert property ((power_step_s and power_state == PWR_OFF) |=> o_sys_power)
    else $error("power did not switch on after short hold");
  power_off_a: assert property ((power_step_s and power_state == PWR_ON) |=> !o_sys_power)
    else $error("power did not switch off after long hold");
  reset_off_a: assert property (i_reset_btn |=> !o_sys_power && power_state == PWR_OFF)
    else $error("reset button left power on");
  power_rise_a: assert property ($rose(o_sys_power) |-> $past(pwr_fire) && !$past(i_reset_btn))
    else $error("power came on without a hold");
  nmi_gate_a: assert property (o_nmi_req == $past(i_nmi_btn && key_control[NMI_GATE_BIT]))
    else $error("nmi request ignores its gate");
  press_flag_a: assert property (on_evt |=> flags[0])
    else $error("key-on event lost");
  flag_clear_a: assert property ((status_wr && !i_wdata[FLAG_LSB+1] && !off_evt) |=> !flags[1])
    else $error("key-off flag not cleared by write of zero");
  power_flag_a: assert property ((pwr_fire && power_state == PWR_ON) |=> flags[3])
    else $error("power flag missing after long hold");
  no_repeat_a: assert property ((repeat_interval_select == 8'h00) |-> !rep_hold)
    else $error("repeat armed with no interval selected");
  repeat_flag_a: assert property (rep_fire |=> flags[2])
    else $error("repeat event lost");
  summary_a: assert property ((|events) |=> key_summary_flag ##1 (key_summary_flag || !(|flags)))
    else $error("summary bit not following flags");
  irq_a: assert property (##1 o_irq == $past(|(flags & irq_en)))
    else $error("interrupt output not or of enabled flags");
  pattern_a: assert property (i_rd && i_addr == KEY_PATTERN_ADDR |=> o_rdata[15:11] == 5'h00)
    else $error("pattern register upper bits not zero");
endmodule : key_switch_controller
`default_nettype wire

// file: rtl/key_switch_pkg.sv
// constants shared by the key-switch controller files
package key_switch_pkg;
  localparam logic [7:0] KEY_CONTROL_ADDR = 8'h60;
  localparam logic [7:0] REPEAT_SEL_ADDR = 8'h61;
  localparam logic [7:0] KEY_STATUS_ADDR = 8'h62;
  localparam logic [7:0] KEY_PATTERN_ADDR = 8'h64;
  localparam logic [7:0] SUMMARY_ADDR = 8'h90;
  localparam logic [7:0] KEY_CONTROL_RST = 8'h20;
  localparam logic [7:0] REPEAT_SEL_RST = 8'h01;
  localparam logic [3:0] FLAGS_RST = 4'h0;
  localparam logic [15:0] RDATA_RST = 16'h0000;
  localparam int KEY_IN_EN_BIT = 0;
  localparam int IRQ_EN_LSB = 1;
  localparam int NMI_GATE_BIT = 5;
  localparam int FLAG_LSB = 1;
  localparam int SUMMARY_BIT = 2;
  localparam int PAT_SW2_BIT = 8;
  localparam int PAT_SW3_BIT = 10;
  localparam int KEY_COUNT = 7;
  localparam int CURSOR_KEYS = 5;
  localparam int EVENT_COUNT = 4;
  localparam int DEBOUNCE_SAMPLES = 3;
  localparam int CLK_HZ = 100000000;
  localparam int CYCLES_PER_MS = CLK_HZ / 1000;
  localparam int SAMPLE_PERIOD_MS = 10;
  localparam int POWER_ON_HOLD_MS = 500;
  localparam int POWER_OFF_HOLD_MS = 2000;
  localparam int REPEAT_BASE_MS = 100;
  localparam int REPEAT_STEP_MS = 50;
  localparam int SAMPLE_CYCLES = SAMPLE_PERIOD_MS * CYCLES_PER_MS;
  localparam int POWER_ON_CYCLES = POWER_ON_HOLD_MS * CYCLES_PER_MS;
  localparam int POWER_OFF_CYCLES = POWER_OFF_HOLD_MS * CYCLES_PER_MS;
  localparam int REPEAT_BASE_CYCLES = REPEAT_BASE_MS * CYCLES_PER_MS;
  localparam int REPEAT_STEP_CYCLES = REPEAT_STEP_MS * CYCLES_PER_MS;
  typedef enum logic {
    PWR_OFF = 1'b0,
    PWR_ON = 1'b1
  } power_state_t;
  localparam power_state_t POWER_RST = PWR_OFF;
endpackage : key_switch_pkg

// file: testbench/key_buttons_model.sv
// board buttons, cursor switch and push-buttons as seen by the key-switch controller
`timescale 1ns/100ps
`default_nettype none
module key_buttons_model
  import key_switch_pkg::*;
#(
  parameter int FLIP_TICKS = 8
) (
  input wire logic i_sys_clk,
  input wire logic i_rst_b,
  input wire logic i_power_req,
  input wire logic i_reset_req,
  input wire logic i_nmi_req,
  input wire logic [KEY_COUNT-1:0] i_keys_req,
  input wire logic i_chatter,
  output logic o_power_btn,
  output logic o_reset_btn,
  output logic o_nmi_btn,
  output logic [KEY_COUNT-1:0] o_app_keys
);
  logic [7:0] flip_cnt;
  logic bounce;

  // chatter flips key 0 once per sample period, so no three samples ever agree
  always_ff @(posedge i_sys_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      flip_cnt <= 8'h00;
      bounce <= 1'b0;
    end else if (flip_cnt == 8'(FLIP_TICKS - 1)) begin
      flip_cnt <= 8'h00;
      bounce <= ~bounce;
    end else begin
      flip_cnt <= flip_cnt + 8'h01;
    end
  end

  // contacts settle one clock after the request, like a synchronised switch
  always_ff @(posedge i_sys_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      o_power_btn <= 1'b0;
      o_reset_btn <= 1'b0;
      o_nmi_btn <= 1'b0;
      o_app_keys <= '0;
    end else begin
      o_power_btn <= i_power_req;
      o_reset_btn <= i_reset_req;
      o_nmi_btn <= i_nmi_req;
      o_app_keys <= i_keys_req ^ {{(KEY_COUNT-1){1'b0}}, bounce & i_chatter};
    end
  end
endmodule : key_buttons_model
`default_nettype wire

// file: testbench/key_switch_controller_bench.sv
// self-checking bench for the key-switch controller
`timescale 1ns/100ps
`default_nettype none
module key_switch_controller_bench;
  import key_switch_pkg::*;
  logic clk;
  logic rst_b;
  logic [7:0] addr;
  logic [15:0] wdata;
  logic wr_en;
  logic rd_en;
  logic [15:0] rdata;
  logic pwr;
  logic rst_btn;
  logic nmi;
  logic [6:0] keys;
  logic chatter;
  logic b_pwr;
  logic b_rst;
  logic b_nmi;
  logic [6:0] b_keys;
  logic sys_power;
  logic nmi_req;
  logic irq;
  int err_total;
  int compares;
  int cyc;
  int t1;

  // default flip period equals the sample period below, so chatter defeats every vote
  key_buttons_model u_key_buttons_model (
    .i_sys_clk(clk), .i_rst_b(rst_b), .i_power_req(pwr), .i_reset_req(rst_btn),
    .i_nmi_req(nmi), .i_keys_req(keys), .i_chatter(chatter), .o_power_btn(b_pwr),
    .o_reset_btn(b_rst), .o_nmi_btn(b_nmi), .o_app_keys(b_keys));

  // short counts keep the run small; every expectation below uses these figures
  key_switch_controller #(
    .SAMPLE_TICKS(8), .POWER_ON_TICKS(20), .POWER_OFF_TICKS(50),
    .REPEAT_BASE_TICKS(40), .REPEAT_STEP_TICKS(10)
  ) u_key_switch_controller (
    .i_sys_clk(clk), .i_rst_b(rst_b), .i_addr(addr), .i_wdata(wdata), .i_wr(wr_en),
    .i_rd(rd_en), .o_rdata(rdata), .i_power_btn(b_pwr), .i_reset_btn(b_rst),
    .i_nmi_btn(b_nmi), .i_app_keys(b_keys), .o_sys_power(sys_power),
    .o_nmi_req(nmi_req), .o_irq(irq));

  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end

  always @(posedge clk) cyc <= cyc + 1;

  task final_report();
    $display("counts: compares %0d err_total %0d", compares, err_total);
    if (err_total == 0 && compares > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask : final_report

  task chk(input logic [15:0] got, input logic [15:0] exp);
    compares++;
    if (got !== exp) begin
      err_total++;
      $display("mismatch at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk

  task reg_write(input logic [7:0] a, input logic [15:0] d);
    @(posedge clk);
    addr <= a;
    wdata <= d;
    wr_en <= 1'b1;
    @(posedge clk);
    wr_en <= 1'b0;
  endtask : reg_write

  // read data stand only in the cycle after the strobe edge
  task reg_read(input logic [7:0] a, input logic [15:0] exp);
    @(posedge clk);
    addr <= a;
    rd_en <= 1'b1;
    @(posedge clk);
    rd_en <= 1'b0;
    #1;
    chk(rdata, exp);
  endtask : reg_read

  task wait_irq(input logic lvl);
    for (int k = 0; k < 300 && irq !== lvl; k++) begin
      @(posedge clk);
      #1;
    end
    if (irq !== lvl) begin
      err_total++;
      $display("mismatch at %0t: irq %h expected %h", $time, irq, lvl);
      final_report();
    end
  endtask : wait_irq

  // interval between two repeat interrupts, flags cleared in between
  task rep_gap(input logic [7:0] sel, input logic [15:0] exp);
    reg_write(REPEAT_SEL_ADDR, {8'h00, sel});
    reg_write(KEY_STATUS_ADDR, 16'h0000);
    wait_irq(1'b0);
    wait_irq(1'b1);
    t1 = cyc;
    reg_write(KEY_STATUS_ADDR, 16'h0000);
    wait_irq(1'b0);
    wait_irq(1'b1);
    chk(16'(cyc - t1), exp);
  endtask : rep_gap

  // holds the power button for n clocks at the controller's pin
  task press_power(input int n);
    @(posedge clk);
    pwr <= 1'b1;
    repeat (n) @(posedge clk);
    pwr <= 1'b0;
    repeat (4) @(posedge clk);
    #1;
  endtask : press_power

  initial begin
    rst_b = 1'b0;
    addr = 8'h00;
    wdata = 16'h0000;
    wr_en = 1'b0;
    rd_en = 1'b0;
    pwr = 1'b0;
    rst_btn = 1'b0;
    nmi = 1'b0;
    keys = 7'h00;
    chatter = 1'b0;
    err_total = 0;
    compares = 0;
    cyc = 0;
    repeat (8) @(posedge clk);
    rst_b <= 1'b1;
    #1;
    chk({15'h0000, sys_power}, 16'h0000);
    reg_read(KEY_CONTROL_ADDR, 16'h0020);
    reg_read(REPEAT_SEL_ADDR, 16'h0001);
    reg_read(KEY_STATUS_ADDR, 16'h0000);
    reg_read(SUMMARY_ADDR, 16'h0000);
    reg_write(KEY_PATTERN_ADDR, 16'hFFFF);
    reg_read(KEY_PATTERN_ADDR, 16'h0000);
    reg_read(8'h70, 16'h0000);
    @(posedge clk) nmi <= 1'b1;
    repeat (3) @(posedge clk);
    #1 chk({15'h0000, nmi_req}, 16'h0001);
    reg_write(KEY_CONTROL_ADDR, 16'h0000);
    repeat (2) @(posedge clk);
    #1 chk({15'h0000, nmi_req}, 16'h0000);
    @(posedge clk) nmi <= 1'b0;
    // keys ignored while input is disabled
    keys <= 7'h61;
    repeat (40) @(posedge clk);
    reg_read(KEY_PATTERN_ADDR, 16'h0000);
    reg_read(KEY_STATUS_ADDR, 16'h0000);
    @(posedge clk) keys <= 7'h00;
    reg_write(REPEAT_SEL_ADDR, 16'h0000);
    reg_write(KEY_CONTROL_ADDR, 16'h003F);
    @(posedge clk) keys <= 7'h61;
    repeat (15) @(posedge clk);
    reg_read(KEY_PATTERN_ADDR, 16'h0000);
    repeat (24) @(posedge clk);
    reg_read(KEY_PATTERN_ADDR, 16'h0501);
    reg_read(KEY_STATUS_ADDR, 16'h0002);
    chk({15'h0000, irq}, 16'h0001);
    reg_read(SUMMARY_ADDR, 16'h0004);
    reg_write(SUMMARY_ADDR, 16'h0000);
    reg_read(SUMMARY_ADDR, 16'h0000);
    reg_read(KEY_STATUS_ADDR, 16'h0002);
    reg_write(KEY_STATUS_ADDR, 16'h0000);
    reg_read(KEY_STATUS_ADDR, 16'h0000);
    reg_read(SUMMARY_ADDR, 16'h0000);
    chk({15'h0000, irq}, 16'h0000);
    rep_gap(8'h06, 16'h0032);
    rep_gap(8'h80, 16'h006E);
    // release with its interrupt masked: flag sets, request stays low
    reg_write(REPEAT_SEL_ADDR, 16'h0000);
    reg_write(KEY_STATUS_ADDR, 16'h0000);
    reg_write(KEY_CONTROL_ADDR, 16'h003B);
    @(posedge clk) keys <= 7'h00;
    repeat (48) @(posedge clk);
    reg_read(KEY_STATUS_ADDR, 16'h0004);
    chk({15'h0000, irq}, 16'h0000);
    reg_read(KEY_PATTERN_ADDR, 16'h0000);
    reg_write(KEY_STATUS_ADDR, 16'h0000);
    @(posedge clk);
    keys <= 7'h01;
    chatter <= 1'b1;
    repeat (80) @(posedge clk);
    reg_read(KEY_PATTERN_ADDR, 16'h0000);
    reg_read(KEY_STATUS_ADDR, 16'h0000);
    @(posedge clk);
    keys <= 7'h00;
    chatter <= 1'b0;
    press_power(19);
    chk({15'h0000, sys_power}, 16'h0000);
    press_power(21);
    chk({15'h0000, sys_power}, 16'h0001);
    press_power(45);
    chk({15'h0000, sys_power}, 16'h0001);
    press_power(52);
    chk({15'h0000, sys_power}, 16'h0000);
    reg_read(KEY_STATUS_ADDR, 16'h0010);
    chk({15'h0000, irq}, 16'h0001);
    press_power(21);
    chk({15'h0000, sys_power}, 16'h0001);
    @(posedge clk) rst_btn <= 1'b1;
    repeat (3) @(posedge clk);
    #1 chk({15'h0000, sys_power}, 16'h0000);
    @(posedge clk) rst_btn <= 1'b0;
    // second reset in mid-run: registers return to their reset values
    rst_b <= 1'b0;
    repeat (2) @(posedge clk);
    rst_b <= 1'b1;
    reg_read(KEY_CONTROL_ADDR, 16'h0020);
    reg_read(REPEAT_SEL_ADDR, 16'h0001);
    reg_read(KEY_STATUS_ADDR, 16'h0000);
    final_report();
  end
endmodule : key_switch_controller_bench
`default_nettype wire
